// [hw/sfc_checker.v]
// Behaviour
// - Variant one: load device permanent read check reports message A.
// - Variant one: defective track pointer equal to own address reports B.
// - Variant two format 0: sense bytes 8 to 19 read zero.
// - Byte 20 holds controller id only when operator and environmental flags set.
// - Byte 21 holds director id; bytes 22 and 23 the symptom code.
// - Operator flag selects program-check or soft-error-logging message set.
// - Unsupported or uninstalled-feature command reports message 1.
// - Read/search/head seek/space/diag home address write needs prior positioning command.
// - Locate needs prior define extent or initial-load read; domain commands checked.
// - Unconditional reserve not first in chain is invalid sequence.
// - Short counts: seek 6, space 3, path id 12, mode 2, diag ctl 4.
// - Short counts: extent 16, locate 16, home address write 5, diag home address write 28.
// - File mask with bit 2 or bit 6 set reports message 4.
// - Diag control byte 0 not 02/08, or bytes 2-3 nonzero, is invalid.
// - Byte 0 02 needs byte 1 80/40/20; byte 0 08 needs byte 1 zero.
// - Diag control or diag home address access forbidden by mask bit 5 reports 5.
// - No chaining after retry status reports message 6.
// - Variant two: defective or alternate pointer to itself reports B.
// - Path selection cabling or feature fault reports message C.
// - Operator set, message 1: device logging done; ids in 21, 20, byte 4.
// - Operator set, message 2: controller logging done; its id in byte 20.
// - Operator set, message F: subsystem storage logging done.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`include "sfc_consts.vh"

module sfc_checker #(
	parameter SYMPTOM_RESET = 16'h0000
)(
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Sense status
	output wire [3:0]  msg_code,
	output wire        check_flag
);

	////////////////////////////////////////////////////////////////////////
	// Bus handshake state
	reg         awr_q;
	reg         wr_q;
	reg         bv_q;
	reg [1:0]   bresp_q;
	reg         arr_q;
	reg         rv_q;
	reg [31:0]  rdata_q;
	reg [1:0]   rresp_q;
	reg [11:0]  awaddr_q;
	reg         aw_have_q;
	reg [31:0]  wdata_q;
	reg [3:0]   wstrb_q;
	reg         w_have_q;

	// Software-visible state and hidden chain history
	reg [31:0]  ctrl_q;
	reg [7:0]   fmask_q;
	reg [15:0]  symptom_q;
	reg [3:0]   msg_q;
	reg         chk_q;
	reg         has_pos_q;
	reg         has_ext_q;
	reg         in_dom_q;
	reg         first_q;
	reg         retry_q;

	wire        do_wr = aw_have_q && w_have_q && !bv_q;
	wire [31:0] wd    = wdata_q;

	// Address and data capture, either order; response once both are held
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awr_q     <= 1'b0;
			wr_q      <= 1'b0;
			bv_q      <= 1'b0;
			bresp_q   <= 2'b00;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end
		else
		begin
			awr_q <= !aw_have_q && !awr_q && s_axi_awvalid;
			wr_q  <= !w_have_q && !wr_q && s_axi_wvalid;
			if (s_axi_awvalid && awr_q)
			begin
				awaddr_q  <= s_axi_awaddr;
				aw_have_q <= 1'b1;
			end
			if (s_axi_wvalid && wr_q)
			begin
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
				w_have_q <= 1'b1;
			end
			if (do_wr)
			begin
				bv_q      <= 1'b1;
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bresp_q   <= (awaddr_q <= `SFC_OFF_EVENT) ? 2'b00 : 2'b10;
			end
			else if (bv_q && s_axi_bready)
				bv_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command decode from a write to the command register
	// Command word: [7:0] opcode, [23:8] transfer count
	wire        cmd_wr  = do_wr && awaddr_q == `SFC_OFF_CMD && (&wstrb_q[2:0]);
	wire        arg_wr  = do_wr && awaddr_q == `SFC_OFF_ARG;
	wire        ev_wr   = do_wr && awaddr_q == `SFC_OFF_EVENT;
	wire [7:0]  op      = wd[7:0];
	wire [15:0] cnt     = wd[23:8];
	reg  [31:0] arg_q;
	reg  [3:0]  cmd_msg;
	reg         known;

	// Priority: invalid command, sequence, count, argument, mask
	always @*
	begin
		cmd_msg = `SFC_MSG_NONE;
		known   = 1'b1;
		case (op)
		`SFC_CMD_SEEK, `SFC_CMD_SEEKCYL, `SFC_CMD_SEEKHEAD, `SFC_CMD_RECAL,
		`SFC_CMD_LOCATE, `SFC_CMD_DEFEXT, `SFC_CMD_IPLREAD, `SFC_CMD_READ,
		`SFC_CMD_SEARCH, `SFC_CMD_SPACECNT, `SFC_CMD_DIAGWRHA, `SFC_CMD_DIAGRDHA,
		`SFC_CMD_UNCRSV, `SFC_CMD_SETPGID, `SFC_CMD_SETMODE, `SFC_CMD_DIAGCTL,
		`SFC_CMD_SETFMASK, `SFC_CMD_WRHA, `SFC_CMD_CONTROL, `SFC_CMD_SENSE:
			known = 1'b1;
		`SFC_CMD_OPTFEAT:
			known = !ctrl_q[`SFC_CTRL_NOFEAT];
		default:
			known = 1'b0;
		endcase
		if (!known)
			cmd_msg = `SFC_MSG_INVCMD;
		else if ((op == `SFC_CMD_READ || op == `SFC_CMD_SEARCH ||
			op == `SFC_CMD_SEEKHEAD || op == `SFC_CMD_SPACECNT ||
			op == `SFC_CMD_DIAGWRHA) && !has_pos_q)
			cmd_msg = `SFC_MSG_INVSEQ;
		else if (op == `SFC_CMD_LOCATE && !has_ext_q)
			cmd_msg = `SFC_MSG_INVSEQ;
		else if (in_dom_q && (op == `SFC_CMD_CONTROL || op == `SFC_CMD_SEARCH ||
			op == `SFC_CMD_SENSE || op == `SFC_CMD_DIAGRDHA ||
			op == `SFC_CMD_DIAGWRHA))
			cmd_msg = `SFC_MSG_INVSEQ;
		else if (op == `SFC_CMD_UNCRSV && !first_q)
			cmd_msg = `SFC_MSG_INVSEQ;
		else if (((op == `SFC_CMD_SEEK || op == `SFC_CMD_SEEKCYL ||
			op == `SFC_CMD_SEEKHEAD) && cnt < `SFC_MIN_SEEK) ||
			(op == `SFC_CMD_SPACECNT && cnt < `SFC_MIN_SPACECNT) ||
			(op == `SFC_CMD_SETPGID && cnt < `SFC_MIN_SETPGID) ||
			(op == `SFC_CMD_SETMODE && cnt < `SFC_MIN_SETMODE) ||
			(op == `SFC_CMD_DIAGCTL && cnt < `SFC_MIN_DIAGCTL))
			cmd_msg = `SFC_MSG_SHORTCNT;
		else if ((op == `SFC_CMD_DEFEXT && cnt < `SFC_MIN_DEFEXT) ||
			(op == `SFC_CMD_LOCATE && cnt < `SFC_MIN_LOCATE) ||
			(op == `SFC_CMD_WRHA && cnt < `SFC_MIN_WRHA) ||
			(op == `SFC_CMD_DIAGWRHA && cnt < `SFC_MIN_DIAGWRHA))
			cmd_msg = `SFC_MSG_SHORTCNT;
		else if (op == `SFC_CMD_SETFMASK &&
			(arg_q[`SFC_FM_RSVD_HI] || arg_q[`SFC_FM_RSVD_LO]))
			cmd_msg = `SFC_MSG_INVARG;
		else if (op == `SFC_CMD_DIAGCTL &&
			((arg_q[7:0] != `SFC_DC_OP_A && arg_q[7:0] != `SFC_DC_OP_B) ||
			arg_q[31:16] != 16'h0000))
			cmd_msg = `SFC_MSG_INVARG;
		else if (op == `SFC_CMD_DIAGCTL && ((arg_q[7:0] == `SFC_DC_OP_A &&
			arg_q[15:8] != `SFC_DC_SUB_1 && arg_q[15:8] != `SFC_DC_SUB_2 &&
			arg_q[15:8] != `SFC_DC_SUB_3) ||
			(arg_q[7:0] == `SFC_DC_OP_B && arg_q[15:8] != 8'h00)))
			cmd_msg = `SFC_MSG_INVARG;
		else if ((op == `SFC_CMD_DIAGCTL || op == `SFC_CMD_DIAGRDHA ||
			op == `SFC_CMD_DIAGWRHA) && fmask_q[`SFC_FM_DIAG])
			cmd_msg = `SFC_MSG_FMASK;
	end

	////////////////////////////////////////////////////////////////////////
	// Chain tracking, control, argument and sense message state
	wire newchain = do_wr && awaddr_q == `SFC_OFF_CTRL && wd[`SFC_CTRL_NEWCHAIN];
	wire opmsg    = ctrl_q[`SFC_CTRL_OPMSG];

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q    <= `SFC_CTRL_RESET;
			arg_q     <= 32'h0000_0000;
			fmask_q   <= 8'h00;
			symptom_q <= SYMPTOM_RESET;
			msg_q     <= `SFC_MSG_NONE;
			chk_q     <= 1'b0;
			has_pos_q <= 1'b0;
			has_ext_q <= 1'b0;
			in_dom_q  <= 1'b0;
			first_q   <= 1'b1;
			retry_q   <= 1'b0;
		end
		else
		begin
			if (do_wr && awaddr_q == `SFC_OFF_CTRL)
				ctrl_q <= {wd[31:4], 1'b0, wd[2:0]};
			if (arg_wr)
				arg_q <= wd;
			// New chain clears sequence history only
			if (newchain)
			begin
				has_pos_q <= 1'b0;
				has_ext_q <= 1'b0;
				in_dom_q  <= 1'b0;
				first_q   <= 1'b1;
			end
			if (cmd_wr && !opmsg)
			begin
				msg_q     <= cmd_msg;
				chk_q     <= cmd_msg != `SFC_MSG_NONE;
				first_q   <= 1'b0;
				if (cmd_msg == `SFC_MSG_NONE)
				begin
					if (op == `SFC_CMD_SEEK || op == `SFC_CMD_SEEKCYL ||
						op == `SFC_CMD_LOCATE || op == `SFC_CMD_IPLREAD ||
						op == `SFC_CMD_RECAL)
						has_pos_q <= 1'b1;
					if (op == `SFC_CMD_DEFEXT || op == `SFC_CMD_IPLREAD)
						has_ext_q <= 1'b1;
					if (op == `SFC_CMD_LOCATE)
						in_dom_q <= 1'b1;
					if (op == `SFC_CMD_SETFMASK)
						fmask_q <= arg_q[7:0];
				end
			end
			// Retry status awaits the next command write; a new chain leaves it set
			if (ev_wr && wd[`SFC_EV_RETRY])
				retry_q <= 1'b1;
			else if (cmd_wr)
				retry_q <= 1'b0;
			// Hardware events; the last event written wins the message
			if (ev_wr)
			begin
				symptom_q <= wd[31:16];
				if (opmsg && wd[`SFC_EV_SEL_STOR])
					msg_q <= `SFC_MSG_SEL_STOR;
				else if (opmsg && wd[`SFC_EV_SEL_CTL])
					msg_q <= `SFC_MSG_SEL_CTL;
				else if (opmsg && wd[`SFC_EV_SEL_DEV])
					msg_q <= `SFC_MSG_SEL_DEV;
				else if (!opmsg && retry_q && wd[`SFC_EV_NOCHAIN])
					msg_q <= `SFC_MSG_NORETRY;
				else if (!opmsg && !ctrl_q[`SFC_CTRL_VARIANT] && wd[`SFC_EV_LOADRD])
					msg_q <= `SFC_MSG_LOADRD;
				else if (!opmsg && !ctrl_q[`SFC_CTRL_VARIANT] && wd[`SFC_EV_DEFSELF])
					msg_q <= `SFC_MSG_SELFPTR;
				else if (!opmsg && ctrl_q[`SFC_CTRL_VARIANT] &&
					(wd[`SFC_EV_DEFSELF] || wd[`SFC_EV_ALTSELF]))
					msg_q <= `SFC_MSG_SELFPTR;
				else if (!opmsg && wd[`SFC_EV_PATHCFG])
					msg_q <= `SFC_MSG_PATHCFG;
				chk_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sense byte assembly
	wire [7:0] sb4  = {4'h0, ctrl_q[`SFC_CTRL_DEVID_LO +: 4]};
	wire [7:0] sb20 = (opmsg && ctrl_q[`SFC_CTRL_ENVDATA]) ?
		ctrl_q[`SFC_CTRL_CTLID_LO +: 8] : 8'h00;
	wire [7:0] sb21 = ctrl_q[`SFC_CTRL_DIRID_LO +: 8];

	// Read side; sense words hold bytes 4..23, four to a word, low byte first
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arr_q   <= 1'b0;
			rv_q    <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'b00;
		end
		else
		begin
			arr_q <= !rv_q && !arr_q && s_axi_arvalid;
			if (s_axi_arvalid && arr_q)
			begin
				rv_q    <= 1'b1;
				rresp_q <= 2'b00;
				case (s_axi_araddr)
				`SFC_OFF_CTRL:   rdata_q <= ctrl_q;
				`SFC_OFF_ARG:    rdata_q <= arg_q;
				`SFC_OFF_STATUS: rdata_q <= {8'h00, fmask_q, 3'h0, retry_q,
					chk_q, opmsg, 2'b00, msg_q, 4'h0};
				`SFC_OFF_SENSE0: rdata_q <= {24'h0, sb4};
				`SFC_OFF_SENSE1: rdata_q <= 32'h0000_0000;
				`SFC_OFF_SENSE2: rdata_q <= 32'h0000_0000;
				`SFC_OFF_SENSE3: rdata_q <= 32'h0000_0000;
				`SFC_OFF_SENSE4: rdata_q <= {symptom_q[7:0], symptom_q[15:8],
					sb21, sb20};
				`SFC_OFF_CMD, `SFC_OFF_EVENT: rdata_q <= 32'h0000_0000;
				default:
				begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= 2'b10;
				end
				endcase
			end
			else if (rv_q && s_axi_rready)
				rv_q <= 1'b0;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awr_q;
	assign s_axi_wready  = wr_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign msg_code      = msg_q;
	assign check_flag    = chk_q;

endmodule // sfc_checker

// [hw/sfc_consts.vh]
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH
// Register byte offsets
`define SFC_OFF_CTRL      12'h000
`define SFC_OFF_CMD       12'h004
`define SFC_OFF_ARG       12'h008
`define SFC_OFF_EVENT     12'h00c
`define SFC_OFF_STATUS    12'h010
`define SFC_OFF_SENSE0    12'h014
`define SFC_OFF_SENSE1    12'h018
`define SFC_OFF_SENSE2    12'h01c
`define SFC_OFF_SENSE3    12'h020
`define SFC_OFF_SENSE4    12'h024
`define SFC_OFF_SENSE5    12'h028
// Control register fields
`define SFC_CTRL_VARIANT  0
`define SFC_CTRL_OPMSG    1
`define SFC_CTRL_ENVDATA  2
`define SFC_CTRL_NEWCHAIN 3
`define SFC_CTRL_DEVID_LO 4
`define SFC_CTRL_DIRID_LO 8
`define SFC_CTRL_CTLID_LO 16
`define SFC_CTRL_NOFEAT   29
`define SFC_CTRL_RESET    32'h0000_0000
// Command codes (8-bit)
`define SFC_CMD_SEEK      8'h07
`define SFC_CMD_SEEKCYL   8'h0b
`define SFC_CMD_SEEKHEAD  8'h1b
`define SFC_CMD_RECAL     8'h13
`define SFC_CMD_LOCATE    8'h47
`define SFC_CMD_DEFEXT    8'h63
`define SFC_CMD_IPLREAD   8'h02
`define SFC_CMD_READ      8'h06
`define SFC_CMD_SEARCH    8'h31
`define SFC_CMD_SPACECNT  8'h0f
`define SFC_CMD_DIAGWRHA  8'h19
`define SFC_CMD_DIAGRDHA  8'h1a
`define SFC_CMD_UNCRSV    8'h14
`define SFC_CMD_SETPGID   8'haf
`define SFC_CMD_SETMODE   8'h87
`define SFC_CMD_DIAGCTL   8'hf3
`define SFC_CMD_SETFMASK  8'h1f
`define SFC_CMD_WRHA      8'h0d
`define SFC_CMD_CONTROL   8'h03
`define SFC_CMD_SENSE     8'h04
`define SFC_CMD_OPTFEAT   8'ha7
// Minimum transfer counts
`define SFC_MIN_SEEK      16'd6
`define SFC_MIN_SPACECNT  16'd3
`define SFC_MIN_SETPGID   16'd12
`define SFC_MIN_SETMODE   16'd2
`define SFC_MIN_DIAGCTL   16'd4
`define SFC_MIN_DEFEXT    16'd16
`define SFC_MIN_LOCATE    16'd16
`define SFC_MIN_WRHA      16'd5
`define SFC_MIN_DIAGWRHA  16'd28
// Diagnostic control argument values
`define SFC_DC_OP_A       8'h02
`define SFC_DC_OP_B       8'h08
`define SFC_DC_SUB_1      8'h80
`define SFC_DC_SUB_2      8'h40
`define SFC_DC_SUB_3      8'h20
// File-mask bits
`define SFC_FM_RSVD_HI    2
`define SFC_FM_RSVD_LO    6
`define SFC_FM_DIAG       5
// Message codes
`define SFC_MSG_NONE      4'h0
`define SFC_MSG_INVCMD    4'h1
`define SFC_MSG_INVSEQ    4'h2
`define SFC_MSG_SHORTCNT  4'h3
`define SFC_MSG_INVARG    4'h4
`define SFC_MSG_FMASK     4'h5
`define SFC_MSG_NORETRY   4'h6
`define SFC_MSG_LOADRD    4'ha
`define SFC_MSG_SELFPTR   4'hb
`define SFC_MSG_PATHCFG   4'hc
`define SFC_MSG_SEL_DEV   4'h1
`define SFC_MSG_SEL_CTL   4'h2
`define SFC_MSG_SEL_STOR  4'hf
// Event register bits
`define SFC_EV_LOADRD     0
`define SFC_EV_DEFSELF    1
`define SFC_EV_ALTSELF    2
`define SFC_EV_PATHCFG    3
`define SFC_EV_RETRY      4
`define SFC_EV_NOCHAIN    5
`define SFC_EV_SEL_DEV    6
`define SFC_EV_SEL_CTL    7
`define SFC_EV_SEL_STOR   8
`define SFC_EV_UNINST     9
`endif

// [verification/sfc_checker_properties.sv]
// Port-level timing of the sense checker, seen from outside only
module sfc_props (
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Write channels
	input wire [11:0] s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	// Read channels
	input wire [11:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// Sense status
	input wire [3:0]  msg_code,
	input wire        check_flag
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Read data follows the address handshake; answers stand until the host takes them
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// Unused sense bytes never leak stale data; writes past the event register are refused
	a_zero_sense: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr inside {12'h018, 12'h01c, 12'h020}
		|=> s_axi_rdata == 32'h0000_0000) else $error("sense bytes 8 to 19 not zero");
	a_write_refused: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr > 12'h00c
		|-> ##[1:4] (s_axi_bvalid && s_axi_bresp == 2'b10)) else $error("write not refused");
	// Reset must be checked while reset is low, so no disable here
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn
		|=> !s_axi_bvalid && !s_axi_rvalid && msg_code == 4'h0 && !check_flag)
		else $error("outputs not idle after reset");
	a_flag_on_msg: assert property (msg_code != 4'h0 |-> ##[0:1] check_flag)
		else $error("check flag missing");
	a_msg_quiet: assert property ((!s_axi_awvalid) [*3] |=> $stable(msg_code))
		else $error("message changed without a write");

	// Main scenarios reached
	c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
	c_soft_log: cover property (msg_code == 4'hf);
	c_no_chain: cover property (msg_code == 4'h6);
endmodule // sfc_props

bind sfc_checker sfc_props i_sfc_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .msg_code(msg_code),
	.check_flag(check_flag)
);

// [verification/sfc_host.sv]
// Host channel: issues register cycles, one write or one read at a time
module sfc_host (
	// Clock
	input  wire         aclk,
	// Write channels
	output logic [11:0] s_axi_awaddr,
	output logic        s_axi_awvalid,
	input  wire         s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	output logic        s_axi_wvalid,
	input  wire         s_axi_wready,
	input  wire  [1:0]  s_axi_bresp,
	input  wire         s_axi_bvalid,
	output logic        s_axi_bready,
	// Read channels
	output logic [11:0] s_axi_araddr,
	output logic        s_axi_arvalid,
	input  wire         s_axi_arready,
	input  wire  [31:0] s_axi_rdata,
	input  wire  [1:0]  s_axi_rresp,
	input  wire         s_axi_rvalid,
	output logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic hang;

	// Idle bus from time zero
	initial
	begin
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		hang = 1'b0;
	end

	// Released address and data lines take the inverse so nothing leans on a stale value
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		hang = 1'b1;
		while (hang && n < 40)
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				{s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (s_axi_wvalid && s_axi_wready)
				{s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
			if (s_axi_bvalid && s_axi_bready)
			begin
				{r, hang} = {s_axi_bresp, 1'b0};
				s_axi_bready <= 1'b0;
			end
		end
	endtask

	// Read: address released at its handshake, data taken with rvalid
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		hang = 1'b1;
		while (hang && n < 40)
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				{s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
			if (s_axi_rvalid && s_axi_rready)
			begin
				{d, r, hang} = {s_axi_rdata, s_axi_rresp, 1'b0};
				s_axi_rready <= 1'b0;
			end
		end
	endtask
endmodule // sfc_host

// [verification/tb_top.sv]
`include "sfc_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	function automatic logic [31:0] cw(input logic [7:0] o, input int n);
		return {8'h00, n[15:0], o};
	endfunction
	function automatic logic [31:0] bt(input int n);
		return 32'h1 << n;
	endfunction
	localparam logic [31:0] NC = bt(`SFC_CTRL_NEWCHAIN);
	localparam logic [31:0] OP = NC | bt(`SFC_CTRL_OPMSG);
	localparam logic [31:0] CV = NC | bt(`SFC_CTRL_VARIANT);
	localparam logic [31:0] S6 = cw(`SFC_CMD_SEEK, 6);
	localparam logic [31:0] D4 = cw(`SFC_CMD_DIAGCTL, 4);
	localparam logic [31:0] FM = cw(`SFC_CMD_SETFMASK, 1);
	localparam logic [11:0] NA = 12'hfff;
	localparam logic [11:0] CM = `SFC_OFF_CMD;
	localparam logic [11:0] EV = `SFC_OFF_EVENT;
	typedef struct {
		logic [31:0] ctrl;
		logic [11:0] pa;
		logic [31:0] pd;
		logic [31:0] arg;
		logic [11:0] fa;
		logic [31:0] fd;
		logic [3:0]  exp;
	} sfc_row_t;
	// Bus and status nets
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb, msg_code;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        check_flag;
	int          errors = 0;
	int          cmp_count = 0;
	sfc_row_t    rows[$];
	sfc_row_t    t;

	sfc_checker i_sfc_checker (.*);
	sfc_host i_sfc_host (.*);
	// 40 MHz
	always #12.5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			errors++;
			$display("MISMATCH %0t got %h want %h", $time, seen, want);
		end
	endtask
	task report_and_stop;
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// A hung handshake ends the run as a mismatch
	task guard;
		if (i_sfc_host.hang)
		begin
			errors++;
			report_and_stop;
		end
	endtask
	task w(input logic [11:0] a, input logic [31:0] d);
		i_sfc_host.wr(a, d, 4'hf, rs);
		guard;
	endtask
	task r(input logic [11:0] a);
		i_sfc_host.rd(a, rd, rs);
		guard;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		rows = '{
			'{CV, NA, 0, 0, CM, cw(8'hff, 1), 4'h1},
			'{CV | bt(`SFC_CTRL_NOFEAT), NA, 0, 0, CM, cw(`SFC_CMD_OPTFEAT, 1), 4'h1},
			'{CV, NA, 0, 0, CM, cw(`SFC_CMD_READ, 8), 4'h2},
			'{CV, CM, S6, 0, CM, cw(`SFC_CMD_READ, 8), 4'h0},
			'{CV, NA, 0, 0, CM, cw(`SFC_CMD_LOCATE, 16), 4'h2},
			'{CV, CM, S6, 0, CM, cw(`SFC_CMD_UNCRSV, 1), 4'h2},
			'{CV, NA, 0, 0, CM, cw(`SFC_CMD_SEEK, 5), 4'h3},
			'{CV, CM, S6, 0, CM, cw(`SFC_CMD_SPACECNT, 2), 4'h3},
			'{CV, NA, 0, 0, CM, cw(`SFC_CMD_SETPGID, 11), 4'h3},
			'{CV, NA, 0, 0, CM, cw(`SFC_CMD_SETMODE, 1), 4'h3},
			'{CV, NA, 0, 32'h8002, CM, cw(`SFC_CMD_DIAGCTL, 3), 4'h3},
			'{CV, NA, 0, 0, CM, cw(`SFC_CMD_DEFEXT, 15), 4'h3},
			'{CV, CM, cw(`SFC_CMD_DEFEXT, 16), 0, CM, cw(`SFC_CMD_LOCATE, 15), 4'h3},
			'{CV, NA, 0, 0, CM, cw(`SFC_CMD_WRHA, 4), 4'h3},
			'{CV, CM, S6, 0, CM, cw(`SFC_CMD_DIAGWRHA, 27), 4'h3},
			'{CV, NA, 0, bt(`SFC_FM_RSVD_HI), CM, FM, 4'h4},
			'{CV, NA, 0, bt(`SFC_FM_RSVD_LO), CM, FM, 4'h4},
			'{CV, NA, 0, 32'h8002, CM, D4, 4'h0},
			'{CV, NA, 0, 32'h2002, CM, D4, 4'h0},
			'{CV, NA, 0, 32'h0008, CM, D4, 4'h0},
			'{CV, NA, 0, 32'h8003, CM, D4, 4'h4},
			'{CV, NA, 0, 32'h1002, CM, D4, 4'h4},
			'{CV, NA, 0, 32'h0808, CM, D4, 4'h4},
			'{CV, NA, 0, 32'h0001_8002, CM, D4, 4'h4},
			'{CV, CM, FM, bt(`SFC_FM_DIAG), CM, cw(`SFC_CMD_DIAGRDHA, 8), 4'h5},
			'{NC, EV, bt(`SFC_EV_RETRY), 0, EV, bt(`SFC_EV_NOCHAIN), 4'h6},
			'{NC, NA, 0, 0, EV, bt(`SFC_EV_LOADRD), 4'ha},
			'{NC, NA, 0, 0, EV, bt(`SFC_EV_DEFSELF), 4'hb},
			'{CV, NA, 0, 0, EV, bt(`SFC_EV_PATHCFG), 4'hc},
			'{CV, NA, 0, 0, EV, bt(`SFC_EV_ALTSELF), 4'hb},
			'{OP, NA, 0, 0, EV, bt(`SFC_EV_SEL_CTL), 4'h2},
			'{OP, NA, 0, 0, EV, bt(`SFC_EV_SEL_STOR), 4'hf},
			'{OP, NA, 0, 0, CM, cw(8'hff, 1), 4'hf}
		};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// Each row starts a fresh chain, then writes the argument and up to two more registers
		foreach (rows[i])
		begin
			t = rows[i];
			w(`SFC_OFF_CTRL, t.ctrl);
			w(`SFC_OFF_ARG, t.arg);
			if (t.pa != NA)
				w(t.pa, t.pd);
			w(t.fa, t.fd);
			r(`SFC_OFF_STATUS);
			check(msg_code, t.exp);
			check(rd[7:4], t.exp);
		end
		// Sense bytes under an operator message with environmental data
		w(`SFC_OFF_CTRL, OP | CV | bt(`SFC_CTRL_ENVDATA) | 32'h005a_3c70);
		w(EV, 32'h1234_0000 | bt(`SFC_EV_SEL_DEV));
		check(msg_code, `SFC_MSG_SEL_DEV);
		r(`SFC_OFF_SENSE0);
		check(rd[3:0], 4'h7);
		for (int k = 0; k < 3; k++)
		begin
			r(`SFC_OFF_SENSE1 + 12'(4 * k));
			check(rd, 32'h0);
		end
		r(`SFC_OFF_SENSE4);
		check(rd, 32'h3412_3c5a);
		w(`SFC_OFF_CTRL, OP | CV | 32'h005a_3c70);
		r(`SFC_OFF_SENSE4);
		check(rd, 32'h3412_3c00);
		// Partial strobe on the command word must not count as a command
		w(`SFC_OFF_CTRL, CV);
		i_sfc_host.wr(CM, cw(`SFC_CMD_READ, 8), 4'h1, rs);
		guard;
		check(msg_code, 4'h1);
		check(check_flag, 1'b1);
		i_sfc_host.wr(`SFC_OFF_STATUS, 32'h0, 4'hf, rs);
		guard;
		check(rs, 2'b10);
		r(12'h030);
		check(rs, 2'b10);
		// Search inside a locate domain is refused
		w(`SFC_OFF_CTRL, CV);
		w(CM, cw(`SFC_CMD_DEFEXT, 16));
		w(CM, cw(`SFC_CMD_LOCATE, 16));
		check(msg_code, 4'h0);
		w(CM, cw(`SFC_CMD_SEARCH, 8));
		check(msg_code, 4'h2);
		// Reset in mid-run clears message and flag
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(msg_code, 4'h0);
		check(check_flag, 1'b0);
		r(`SFC_OFF_CTRL);
		check(rd, `SFC_CTRL_RESET);
		report_and_stop;
	end
endmodule // tb_top
